// *** verilog/dbgcs_pkg.sv ***
// Package for the debug-mode control and status block
`default_nettype none
package dbgcs_pkg;
	localparam logic [11:0] ADDR_TRIG_MATCH = 12'h7a2;
	localparam logic [11:0] ADDR_DBG_CTRL   = 12'h7b0;
	localparam logic [31:0] TRIG_MATCH_RST  = 32'h0000_0000;
	localparam int          VER_LSB         = 28;
	localparam logic [3:0]  VER_VAL         = 4'h4;
	localparam int          EBRK_BIT        = 15;
	localparam int          STEPIE_BIT      = 11;
	localparam int          STOPCNT_BIT     = 10;
	localparam int          STOPTIME_BIT    = 9;
	localparam int          CAUSE_LSB       = 6;
	localparam int          MPRVEN_BIT      = 4;
	localparam int          NMIP_BIT        = 3;
	localparam int          STEP_BIT        = 2;
	localparam logic [1:0]  PRV_MACHINE     = 2'h3;
	localparam logic [3:0]  MSIZE_MASKED    = 4'h1;
	localparam logic [2:0]  CAUSE_NONE      = 3'h0;
	localparam logic [2:0]  CAUSE_EBREAK    = 3'h1;
	localparam logic [2:0]  CAUSE_TRIGGER   = 3'h2;
	localparam logic [2:0]  CAUSE_HALTREQ   = 3'h3;
	localparam logic [2:0]  CAUSE_STEP      = 3'h4;
	localparam logic [2:0]  CAUSE_RSTHALT   = 3'h5;

	// Register access request from the pipeline
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [11:0] addr;
		logic [31:0] wdata;
	} dbgcs_csr_req_t;

	// Entry reasons seen in one cycle
	typedef struct packed {
		logic trigger;
		logic ebreak;
		logic rst_halt;
		logic halt_req;
		logic step_done;
	} dbgcs_entry_t;

	// Trigger configuration from the trigger control register
	typedef struct packed {
		logic [3:0] msize;
		logic       execute;
		logic       store;
		logic       load;
	} dbgcs_trig_cfg_t;
endpackage
`default_nettype wire

// *** verilog/dbgcs_core.sv ***
// Debug-mode control and status registers with trigger compare
// Overview of operation
// - Trigger match register holds 32-bit address or store data compare value.
// - Instruction address compares ignore bit zero of the match value.
// - Match-size one treats the match register as a mask.
// - Masked match compares top 31 minus lowest-zero-index bits.
// - Control register access outside Debug Mode raises illegal instruction.
// - Version field bits 31:28 read-only, always 4.
// - Breakpoint-enable set: machine ebreak enters Debug Mode, else ordinary exception.
// - Step-interrupt-enable zero blocks interrupts while stepping; one allows them.
// - Stop-count set freezes counters in Debug Mode and on entering ebreak.
// - Stop-time bit reads zero; timers keep running in Debug Mode.
// - Cause field records entry reason codes one to five.
// - Simultaneous reasons report highest priority: trigger, ebreak, reset halt, halt, step.
// - Halt out of reset reports cause five.
// - Read-only bit shows a pending non-maskable interrupt.
// - Step set outside Debug Mode runs one instruction then enters Debug Mode.
// - Stepped instruction with exception enters Debug Mode before the trap handler.
// - Privilege field always reads 3, machine mode.
// - Memory-privilege enable bit reads zero.
`default_nettype none
module dbgcs_core (
	// Clock and reset
	input  wire logic                       sys_clk,
	input  wire logic                       nrst,
	// Register access
	input  wire dbgcs_pkg::dbgcs_csr_req_t  csr_req,
	output logic [31:0]                     csr_rdata,
	output logic                            csr_illegal,
	// Hart state
	input  wire logic                       debug_mode,
	input  wire logic                       nmi_pending,
	input  wire logic                       ebreak_exec,
	input  wire logic                       instr_retired,
	input  wire logic                       instr_exception,
	input  wire logic                       irq_request,
	// Entry reasons
	input  wire dbgcs_pkg::dbgcs_entry_t    entry_in,
	// Trigger compare
	input  wire dbgcs_pkg::dbgcs_trig_cfg_t trig_cfg,
	input  wire logic [31:0]                cmp_value,
	input  wire logic                       cmp_is_instr,
	output logic                            trig_hit,
	// Control outputs
	output logic                            enter_debug,
	output logic                            ebreak_to_debug,
	output logic                            ebreak_exception,
	output logic                            irq_allowed,
	output logic                            counters_stop,
	output logic                            step_enable
);
	logic [31:0] trig_match_r;
	logic        ebrk_en_r;
	logic        stepie_r;
	logic        stopcnt_r;
	logic        step_r;
	logic [2:0]  cause_r;
	logic        nmip_r;
	logic [2:0]  cause_nxt;
	logic        any_entry;
	logic        step_entry;
	logic        in_step;
	logic        acc;
	logic        hit_dbg;
	logic        hit_trg;
	logic [31:0] mask;
	logic [31:0] a_val;
	logic [31:0] b_val;

	function automatic logic [31:0] top_mask(input logic [31:0] v);
		logic [31:0] m;
		logic        found;
		m = 32'hffff_ffff;
		found = 1'b0;
		for (int i = 0; i < 32; i++) begin
			if (!found && !v[i]) begin
				found = 1'b1;
				m = 32'hffff_ffff << (i + 1);
			end
		end
		return m;
	endfunction

	assign acc     = csr_req.rd | csr_req.wr;
	assign hit_dbg = csr_req.addr == dbgcs_pkg::ADDR_DBG_CTRL;
	assign hit_trg = csr_req.addr == dbgcs_pkg::ADDR_TRIG_MATCH;
	assign csr_illegal = acc & hit_dbg & ~debug_mode;

	// Trigger match storage
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			trig_match_r <= dbgcs_pkg::TRIG_MATCH_RST;
		end else if (csr_req.wr && hit_trg) begin
			trig_match_r <= csr_req.wdata;
		end
	end

	// Writable control bits; writes outside Debug Mode are dropped
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ebrk_en_r <= 1'b0;
			stepie_r  <= 1'b0;
			stopcnt_r <= 1'b0;
			step_r    <= 1'b0;
		end else if (csr_req.wr && hit_dbg && debug_mode) begin
			ebrk_en_r <= csr_req.wdata[dbgcs_pkg::EBRK_BIT];
			stepie_r  <= csr_req.wdata[dbgcs_pkg::STEPIE_BIT];
			stopcnt_r <= csr_req.wdata[dbgcs_pkg::STOPCNT_BIT];
			step_r    <= csr_req.wdata[dbgcs_pkg::STEP_BIT];
		end
	end

	// Single step: one retired or faulting instruction ends the step
	assign in_step    = step_r & ~debug_mode;
	assign step_entry = in_step & (instr_retired | instr_exception);
	assign step_enable = in_step;

	// Entry priority encoder
	always_comb begin
		cause_nxt = dbgcs_pkg::CAUSE_NONE;
		if (entry_in.trigger) begin
			cause_nxt = dbgcs_pkg::CAUSE_TRIGGER;
		end else if (entry_in.ebreak || (ebreak_exec && ebrk_en_r)) begin
			cause_nxt = dbgcs_pkg::CAUSE_EBREAK;
		end else if (entry_in.rst_halt) begin
			cause_nxt = dbgcs_pkg::CAUSE_RSTHALT;
		end else if (entry_in.halt_req) begin
			cause_nxt = dbgcs_pkg::CAUSE_HALTREQ;
		end else if (entry_in.step_done || step_entry) begin
			cause_nxt = dbgcs_pkg::CAUSE_STEP;
		end
	end
	assign any_entry   = ~debug_mode & (cause_nxt != dbgcs_pkg::CAUSE_NONE);
	assign enter_debug = any_entry;

	// Cause is captured once per entry and then held
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cause_r <= dbgcs_pkg::CAUSE_NONE;
		end else if (any_entry) begin
			cause_r <= cause_nxt;
		end
	end

	// Pin level from another domain passes two flops
	logic nmi_s1_r;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			nmi_s1_r <= 1'b0;
			nmip_r   <= 1'b0;
		end else begin
			nmi_s1_r <= nmi_pending;
			nmip_r   <= nmi_s1_r;
		end
	end

	assign ebreak_to_debug  = ebreak_exec & ebrk_en_r & ~debug_mode;
	assign ebreak_exception = ebreak_exec & ~ebrk_en_r & ~debug_mode;
	// Interrupts pass only when not stepping or stepping with them enabled
	assign irq_allowed   = irq_request & ~debug_mode & (~in_step | stepie_r);
	// Timers are not stopped here: only counters see this
	assign counters_stop = stopcnt_r & (debug_mode | ebreak_to_debug);

	// Trigger compare
	always_comb begin
		mask  = 32'hffff_ffff;
		a_val = cmp_value;
		b_val = trig_match_r;
		if (trig_cfg.msize == dbgcs_pkg::MSIZE_MASKED) begin
			mask = top_mask(trig_match_r);
		end
		if (cmp_is_instr) begin
			mask[0] = 1'b0;
		end
	end
	assign trig_hit = (trig_cfg.load | trig_cfg.store | trig_cfg.execute)
		& (((a_val ^ b_val) & mask) == 32'h0000_0000);

	// Read data, registered
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			csr_rdata <= 32'h0000_0000;
		end else if (csr_req.rd && hit_trg) begin
			csr_rdata <= trig_match_r;
		end else if (csr_req.rd && hit_dbg && debug_mode) begin
			csr_rdata <= '0;
			csr_rdata[31:dbgcs_pkg::VER_LSB]                    <= dbgcs_pkg::VER_VAL;
			csr_rdata[dbgcs_pkg::EBRK_BIT]                      <= ebrk_en_r;
			csr_rdata[dbgcs_pkg::STEPIE_BIT]                    <= stepie_r;
			csr_rdata[dbgcs_pkg::STOPCNT_BIT]                   <= stopcnt_r;
			csr_rdata[dbgcs_pkg::STOPTIME_BIT]                  <= 1'b0;
			csr_rdata[dbgcs_pkg::CAUSE_LSB+2:dbgcs_pkg::CAUSE_LSB] <= cause_r;
			csr_rdata[dbgcs_pkg::MPRVEN_BIT]                    <= 1'b0;
			csr_rdata[dbgcs_pkg::NMIP_BIT]                      <= nmip_r;
			csr_rdata[dbgcs_pkg::STEP_BIT]                      <= step_r;
			csr_rdata[1:0]                                      <= dbgcs_pkg::PRV_MACHINE;
		end else if (csr_req.rd) begin
			csr_rdata <= 32'h0000_0000;
		end
	end

	// Checks
	property p_illegal;
		@(posedge sys_clk) disable iff (!nrst)
		(acc && hit_dbg && !debug_mode) |-> csr_illegal;
	endproperty
	a_illegal: assert property (p_illegal) else $error("control access outside debug not flagged");

	property p_ver;
		@(posedge sys_clk) disable iff (!nrst)
		(csr_req.rd && hit_dbg && debug_mode) |=> (csr_rdata[31:28] == 4'h4 && csr_rdata[1:0] == 2'h3);
	endproperty
	a_ver: assert property (p_ver) else $error("version or privilege wrong");

	property p_ebrk;
		@(posedge sys_clk) disable iff (!nrst)
		(ebreak_exec && !debug_mode) |-> (ebreak_to_debug != ebreak_exception);
	endproperty
	a_ebrk: assert property (p_ebrk) else $error("ebreak routed both or neither way");

	property p_irq;
		@(posedge sys_clk) disable iff (!nrst)
		(in_step && !stepie_r) |-> !irq_allowed;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt passed while stepping");

	property p_cnt;
		@(posedge sys_clk) disable iff (!nrst)
		(stopcnt_r && debug_mode) |-> counters_stop;
	endproperty
	a_cnt: assert property (p_cnt) else $error("counters not stopped");

	property p_prio;
		@(posedge sys_clk) disable iff (!nrst)
		(entry_in.trigger && !debug_mode) |=> (cause_r == 3'h2);
	endproperty
	a_prio: assert property (p_prio) else $error("trigger not top priority");

	property p_hold;
		@(posedge sys_clk) disable iff (!nrst)
		!any_entry |=> (cause_r == $past(cause_r));
	endproperty
	a_hold: assert property (p_hold) else $error("cause changed without entry");

	property p_step;
		@(posedge sys_clk) disable iff (!nrst)
		(step_r && !debug_mode && instr_retired) |-> (enter_debug ##1 cause_r != 3'h0);
	endproperty
	a_step: assert property (p_step) else $error("step did not enter debug");

	property p_instr_lsb;
		@(posedge sys_clk) disable iff (!nrst)
		(cmp_is_instr && trig_cfg.execute && ((cmp_value ^ trig_match_r) == 32'h1)) |-> trig_hit;
	endproperty
	a_instr_lsb: assert property (p_instr_lsb) else $error("bit zero not ignored");

	// A refused write must leave every writable control bit as it was
	property p_drop;
		@(posedge sys_clk) disable iff (!nrst)
		(csr_req.wr && hit_dbg && !debug_mode) |=> ({ebrk_en_r, stepie_r, stopcnt_r, step_r} == $past({ebrk_en_r, stepie_r, stopcnt_r, step_r}));
	endproperty
	a_drop: assert property (p_drop) else $error("control bits changed by refused write");

	property p_ctrl_wr;
		@(posedge sys_clk) disable iff (!nrst)
		(csr_req.wr && hit_dbg && debug_mode) |=> (ebrk_en_r == $past(csr_req.wdata[15]) && stepie_r == $past(csr_req.wdata[11]) && stopcnt_r == $past(csr_req.wdata[10]) && step_r == $past(csr_req.wdata[2]));
	endproperty
	a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write not taken");

	property p_trg_wr;
		@(posedge sys_clk) disable iff (!nrst)
		(csr_req.wr && hit_trg) |=> (trig_match_r == $past(csr_req.wdata));
	endproperty
	a_trg_wr: assert property (p_trg_wr) else $error("match value write lost");

	property p_trg_rd;
		@(posedge sys_clk) disable iff (!nrst)
		(csr_req.rd && hit_trg) |=> (csr_rdata == $past(trig_match_r));
	endproperty
	a_trg_rd: assert property (p_trg_rd) else $error("match value read wrong");

	property p_exact;
		@(posedge sys_clk) disable iff (!nrst)
		(trig_cfg.msize == 4'h0 && (trig_cfg.load || trig_cfg.store || trig_cfg.execute) && !cmp_is_instr) |-> (trig_hit == (cmp_value == trig_match_r));
	endproperty
	a_exact: assert property (p_exact) else $error("exact compare wrong");

	// Compared bits are those above the lowest zero, found here by an add instead of a scan
	property p_masked;
		@(posedge sys_clk) disable iff (!nrst)
		(trig_cfg.msize == 4'h1 && (trig_cfg.load || trig_cfg.store || trig_cfg.execute) && trig_match_r != 32'hffff_ffff) |-> (trig_hit == (((cmp_value ^ trig_match_r) & ~(trig_match_r ^ (trig_match_r + 32'h0000_0001))) == 32'h0000_0000));
	endproperty
	a_masked: assert property (p_masked) else $error("masked compare wrong");

	property p_stoptime;
		@(posedge sys_clk) disable iff (!nrst)
		(csr_req.rd && hit_dbg && debug_mode) |=> (csr_rdata[9] == 1'b0);
	endproperty
	a_stoptime: assert property (p_stoptime) else $error("stop-time bit not zero");

	property p_mprven;
		@(posedge sys_clk) disable iff (!nrst)
		(csr_req.rd && hit_dbg && debug_mode) |=> (csr_rdata[4] == 1'b0);
	endproperty
	a_mprven: assert property (p_mprven) else $error("memory-privilege enable not zero");

	property p_cause_rd;
		@(posedge sys_clk) disable iff (!nrst)
		(csr_req.rd && hit_dbg && debug_mode) |=> (csr_rdata[8:6] == $past(cause_r));
	endproperty
	a_cause_rd: assert property (p_cause_rd) else $error("cause field read wrong");

	property p_rsthalt;
		@(posedge sys_clk) disable iff (!nrst)
		(entry_in.rst_halt && !entry_in.trigger && !entry_in.ebreak && !ebreak_exec && !debug_mode) |=> (cause_r == 3'h5);
	endproperty
	a_rsthalt: assert property (p_rsthalt) else $error("reset halt cause wrong");

	property p_nmip;
		@(posedge sys_clk) disable iff (!nrst)
		($past(nrst, 1) && $past(nrst, 2)) |-> (nmip_r == $past(nmi_pending, 2));
	endproperty
	a_nmip: assert property (p_nmip) else $error("pending interrupt bit lag wrong");

	property p_step_exc;
		@(posedge sys_clk) disable iff (!nrst)
		(step_r && !debug_mode && instr_exception) |-> enter_debug;
	endproperty
	a_step_exc: assert property (p_step_exc) else $error("faulting step did not enter debug");

	property p_step_dbg;
		@(posedge sys_clk) disable iff (!nrst)
		debug_mode |-> !step_enable;
	endproperty
	a_step_dbg: assert property (p_step_dbg) else $error("stepping while in debug");

	property p_irq_on;
		@(posedge sys_clk) disable iff (!nrst)
		(in_step && stepie_r && irq_request) |-> irq_allowed;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("interrupt blocked with step interrupts on");

	// Counters run freely outside debug unless an ebreak enters it; timers never see the stop
	property p_cnt_run;
		@(posedge sys_clk) disable iff (!nrst)
		(!debug_mode && !ebreak_exec) |-> !counters_stop;
	endproperty
	a_cnt_run: assert property (p_cnt_run) else $error("counters stopped while running");

	property p_prio_ebrk;
		@(posedge sys_clk) disable iff (!nrst)
		(entry_in.ebreak && !entry_in.trigger && !debug_mode) |=> (cause_r == 3'h1);
	endproperty
	a_prio_ebrk: assert property (p_prio_ebrk) else $error("ebreak cause priority wrong");
endmodule
`default_nettype wire

// *** sim/dbgcs_dbg_model.sv ***
// Debugger-side model issuing register accesses through the debug module
`default_nettype none
module dbgcs_dbg_model (
	// Clock and hart state
	input  wire logic                      sys_clk,
	input  wire logic                      debug_mode,
	// Register access
	output var  dbgcs_pkg::dbgcs_csr_req_t csr_req,
	input  wire logic [31:0]               csr_rdata,
	input  wire logic                      csr_illegal
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] last_ctrl = 32'h0;
	initial csr_req = '0;
	task automatic access(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic illegal);
		logic [31:0] d;
		d = wdata;
		@(posedge sys_clk);
		// Mode is looked at right after the edge, before nonblocking updates from that edge land, so such a change is not yet seen
		// While running, step and step-interrupt bits repeat the last value read
		if (wr && !debug_mode && addr == dbgcs_pkg::ADDR_DBG_CTRL) begin
			d[dbgcs_pkg::STEPIE_BIT] = last_ctrl[dbgcs_pkg::STEPIE_BIT];
			d[dbgcs_pkg::STEP_BIT]   = last_ctrl[dbgcs_pkg::STEP_BIT];
		end
		csr_req <= '{rd: !wr, wr: wr, addr: addr, wdata: d};
		#1 illegal = csr_illegal;
		@(posedge sys_clk);
		// Released lines carry inverted content so stale values never look fresh
		csr_req <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~d};
		#1 rdata = csr_rdata;
		if (!wr && addr == dbgcs_pkg::ADDR_DBG_CTRL)
			last_ctrl = rdata;
	endtask
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the debug-mode control and status block
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                       sys_clk = 0, nrst = 0, il, debug_mode = 1, nmi_pending = 0, ebreak_exec = 0;
	logic                       instr_retired = 0, instr_exception = 0, irq_request = 0, cmp_is_instr = 0;
	logic                       ebm = 0, stepie = 0, stopc = 0, step_s = 0, nmip_s = 0;
	logic                       csr_illegal, trig_hit, enter_debug, ebreak_to_debug, ebreak_exception;
	logic                       irq_allowed, counters_stop, step_enable;
	logic [31:0]                csr_rdata, r, m, cmp_value = 0;
	logic [2:0]                 cause_s = 0;
	dbgcs_pkg::dbgcs_csr_req_t  csr_req;
	dbgcs_pkg::dbgcs_entry_t    entry_in = '0;
	dbgcs_pkg::dbgcs_trig_cfg_t trig_cfg = '0;
	int                         miscompares = 0, total_checks = 0;
	always #5 sys_clk = ~sys_clk;
	dbgcs_core u_dut (.sys_clk(sys_clk), .nrst(nrst), .csr_req(csr_req), .csr_rdata(csr_rdata),
		.csr_illegal(csr_illegal), .debug_mode(debug_mode), .nmi_pending(nmi_pending), .ebreak_exec(ebreak_exec),
		.instr_retired(instr_retired), .instr_exception(instr_exception), .irq_request(irq_request),
		.entry_in(entry_in), .trig_cfg(trig_cfg), .cmp_value(cmp_value), .cmp_is_instr(cmp_is_instr),
		.trig_hit(trig_hit), .enter_debug(enter_debug), .ebreak_to_debug(ebreak_to_debug),
		.ebreak_exception(ebreak_exception), .irq_allowed(irq_allowed), .counters_stop(counters_stop),
		.step_enable(step_enable));
	dbgcs_dbg_model u_dbg (.sys_clk(sys_clk), .debug_mode(debug_mode), .csr_req(csr_req),
		.csr_rdata(csr_rdata), .csr_illegal(csr_illegal));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	function automatic logic [31:0] exp_ctrl();
		return {dbgcs_pkg::VER_VAL, 12'h000, ebm, 3'h0, stepie, stopc, 1'b0, cause_s, 2'h0, nmip_s, step_s,
			dbgcs_pkg::PRV_MACHINE};
	endfunction
	function automatic logic [2:0] exp_cause(dbgcs_pkg::dbgcs_entry_t e);
		if (e.trigger) return dbgcs_pkg::CAUSE_TRIGGER;
		if (e.ebreak) return dbgcs_pkg::CAUSE_EBREAK;
		if (e.rst_halt) return dbgcs_pkg::CAUSE_RSTHALT;
		if (e.halt_req) return dbgcs_pkg::CAUSE_HALTREQ;
		return dbgcs_pkg::CAUSE_STEP;
	endfunction
	function automatic logic exp_hit(logic [31:0] mv, logic [31:0] v, dbgcs_pkg::dbgcs_trig_cfg_t c, logic ins);
		logic [31:0] k;
		int z = 32;
		for (int b = 31; b >= 0; b--)
			if (!mv[b]) z = b;
		k = (c.msize == dbgcs_pkg::MSIZE_MASKED && z < 32) ? ('1 << (z + 1)) : '1;
		k[0] = k[0] & ~ins;
		return (c.execute | c.store | c.load) && (((mv ^ v) & k) == 32'h0);
	endfunction
	task automatic rctrl();
		u_dbg.access(1'b0, dbgcs_pkg::ADDR_DBG_CTRL, 32'h0, r, il);
		chk(r, exp_ctrl());
	endtask
	task automatic wctrl(input logic [31:0] d);
		u_dbg.access(1'b1, dbgcs_pkg::ADDR_DBG_CTRL, d, r, il);
		chk(il, 0);
		{ebm, stepie, stopc, step_s} = {d[15], d[11:10], d[2]};
	endtask
	initial begin
		repeat (100000) @(posedge sys_clk);
		miscompares++;
		final_report();
	end
	initial begin
		void'($urandom(32'hcd62));
		repeat (12) @(posedge sys_clk);
		nrst <= 1;
		rctrl();
		wctrl(32'hffff_ffff);
		rctrl();
		@(posedge sys_clk) debug_mode <= 0;
		u_dbg.access(1'b1, dbgcs_pkg::ADDR_DBG_CTRL, 32'h0, r, il);
		chk(il, 1);
		@(posedge sys_clk) debug_mode <= 1;
		rctrl();
		u_dbg.access(1'b0, 12'h7a1, 32'h0, r, il);
		chk(r, 0);
		// Every combination of entry reasons in one cycle
		for (int i = 1; i < 32; i++) begin
			@(posedge sys_clk);
			debug_mode <= 0;
			entry_in <= 5'(i);
			#1 chk(enter_debug, 1);
			@(posedge sys_clk);
			entry_in <= '0;
			debug_mode <= 1;
			cause_s = exp_cause(5'(i));
			rctrl();
		end
		// Step ends on retirement, then on an exception
		for (int i = 0; i < 2; i++) begin
			@(posedge sys_clk);
			debug_mode <= 0;
			#1 chk(step_enable, 1);
			chk(enter_debug, 0);
			@(posedge sys_clk);
			instr_retired <= (i == 0);
			instr_exception <= (i == 1);
			#1 chk(enter_debug, 1);
			@(posedge sys_clk);
			{instr_retired, instr_exception, debug_mode} <= 3'b001;
			cause_s = dbgcs_pkg::CAUSE_STEP;
			rctrl();
		end
		for (int j = 0; j < 2; j++) begin
			wctrl(j ? 32'h0000_0804 : 32'h0000_0004);
			@(posedge sys_clk);
			{debug_mode, irq_request} <= 2'b01;
			#1 chk(irq_allowed, j);
			@(posedge sys_clk);
			{debug_mode, irq_request} <= 2'b10;
		end
		for (int j = 0; j < 2; j++) begin
			wctrl(j ? 32'h0000_8400 : 32'h0);
			chk(counters_stop, j);
			@(posedge sys_clk);
			{debug_mode, ebreak_exec} <= 2'b01;
			#1 chk(ebreak_to_debug, j);
			chk(ebreak_exception, !j);
			chk(counters_stop, j);
			@(posedge sys_clk);
			{debug_mode, ebreak_exec} <= 2'b10;
			if (j) cause_s = dbgcs_pkg::CAUSE_EBREAK;
			rctrl();
		end
		@(posedge sys_clk) nmi_pending <= 1;
		nmip_s = 1;
		repeat (3) @(posedge sys_clk);
		rctrl();
		for (int i = 0; i < 60; i++) begin
			m = (i % 2) ? ($urandom | ((32'h1 << (i % 32)) - 32'h1)) : $urandom;
			if (i == 59) m = '1;
			u_dbg.access(1'b1, dbgcs_pkg::ADDR_TRIG_MATCH, m, r, il);
			chk(il, 0);
			u_dbg.access(1'b0, dbgcs_pkg::ADDR_TRIG_MATCH, 32'h0, r, il);
			chk(r, m);
			@(posedge sys_clk);
			trig_cfg <= {3'h0, 1'($urandom), 3'($urandom)};
			cmp_value <= (i % 3 == 0) ? $urandom : (i % 3 == 1) ? m : m ^ (32'h1 << ($urandom % 32));
			cmp_is_instr <= 1'($urandom);
			#1 chk(trig_hit, exp_hit(m, cmp_value, trig_cfg, cmp_is_instr));
		end
		final_report();
	end
endmodule
`default_nettype wire
